/* logic/pst_pkg.sv */
package pst_pkg;
  // register byte offsets from the base address window
  localparam logic [7:0] PST_OFS_PORTSC1 = 8'h64;
  localparam logic [7:0] PST_OFS_PORTSC2 = 8'h68;
  localparam logic [7:0] PST_OFS_TUNING  = 8'h6c;
  localparam logic [7:0] PST_PORT_STRIDE = 8'h04;
  // port status field positions
  localparam int PST_BIT_PRESENT  = 0;
  localparam int PST_BIT_CONN_CHG = 1;
  localparam int PST_BIT_ENABLED  = 2;
  localparam int PST_BIT_EN_CHG   = 3;
  // tuning field positions
  localparam int PST_BIT_WMD = 0;
  localparam int PST_BIT_RBD = 1;
  // reset values
  localparam logic [31:0] PST_TUNING_RST = 32'h0000_0000;
  localparam logic        PST_PORT_RST   = 1'b0;
  // watermark levels in bytes, ascending
  localparam int PST_WM_COUNT = 6;
  localparam logic [10:0] PST_WM_LEVEL [PST_WM_COUNT] =
    '{11'h0bf, 11'h0ff, 11'h17f, 11'h1ff, 11'h27f, 11'h2ff};
  // strap synchroniser depth
  localparam int PST_SYNC_STAGES = 2;
endpackage

/* logic/pst_wm_if.sv */
interface pst_wm_if;
  import pst_pkg::*;
  logic [10:0] pkt_size;
  logic [10:0] fetched;
  logic        wm_off;
  logic        start;
  modport ctrl (output pkt_size, output fetched, output wm_off, input start);
  modport calc (input pkt_size, input fetched, input wm_off, output start);
endinterface

/* logic/pst_watermark.sv */
module pst_watermark
  import pst_pkg::*;
(
  pst_wm_if.calc wm
);
  logic [10:0] level;
  logic        found;

  // largest level strictly below the packet size; none means wait for the whole packet
  always_comb
  begin
    level = wm.pkt_size;
    found = 1'b0;
    for (int i = 0; i < PST_WM_COUNT; i++)
    begin
      if (PST_WM_LEVEL[i] < wm.pkt_size)
      begin
        level = PST_WM_LEVEL[i];
        found = 1'b1;
      end
    end
    if (wm.wm_off || !found)
    begin
      level = wm.pkt_size;
    end
  end

  // see (RULE15) see (RULE19)
  assign wm.start = (wm.pkt_size != 11'h000) && (wm.fetched >= level);
endmodule

/* logic/pst_regs.sv */
// Operation
// (RULE1) enable-change sets only when the port is disabled by end-of-frame errors
// (RULE2) writing one clears enable-change; writing zero leaves it alone
// (RULE3) software writes of one to the enabled bit are ignored
// (RULE4) enabled sets only when reset sequence finds a high-speed device
// (RULE5) enabled clears on fault or software zero, once the port really changed
// (RULE6) disabled port blocks downstream traffic except reset signalling
// (RULE7) connect-change sets on every connect change, stays set if already set
// (RULE8) writing one clears connect-change; writing zero leaves it alone
// (RULE9) bit 0 shows the live attach state of the port
// (RULE10) with port power off the four low port bits read zero
// (RULE11) software writes tuning reserved bits with their reset value
// (RULE12) tuning bit 1 set disables ring buffering for IN transfers
// (RULE13) ring buffering starts the next IN packet right after the last one
// (RULE14) tuning bit 0 set disables the OUT watermark feature
// (RULE15) watermark starts OUT packet once fetched bytes reach the watermark level
// (RULE16) strap high forces ring-buffer-disable to read one and stay off
// (RULE17) strap high forces watermark-disable to read one and stay off
// (RULE18) both tuning disable bits load from the strap level at reset
// (RULE19) use largest level below packet size; small packets wait for all data
module pst_regs
  import pst_pkg::*;
#(
  parameter int NUM_PORTS = 2
)
(
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 reset_i,
  // register access
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  input  wire logic [7:0]           reg_addr_i,
  input  wire logic [31:0]          reg_wdata_i,
  output logic      [31:0]          reg_rdata_o,
  // port engine status
  input  wire logic [NUM_PORTS-1:0] port_power_i,
  input  wire logic [NUM_PORTS-1:0] connect_present_i,
  input  wire logic [NUM_PORTS-1:0] reset_done_hs_i,
  input  wire logic [NUM_PORTS-1:0] eof_error_i,
  input  wire logic [NUM_PORTS-1:0] fault_i,
  input  wire logic [NUM_PORTS-1:0] port_disabled_ack_i,
  input  wire logic [NUM_PORTS-1:0] data_req_i,
  input  wire logic [NUM_PORTS-1:0] reset_sig_i,
  output logic      [NUM_PORTS-1:0] port_enabled_o,
  output logic      [NUM_PORTS-1:0] disable_req_o,
  output logic      [NUM_PORTS-1:0] data_pass_o,
  // strap pin
  input  wire logic                 tuning_strap_pin_i,
  // transfer engines
  input  wire logic                 in_pkt_done_i,
  output logic                      in_start_o,
  input  wire logic [10:0]          out_pkt_size_i,
  input  wire logic [10:0]          out_fetched_i,
  output logic                      out_start_o,
  output logic                      ring_buffer_disable_o,
  output logic                      watermark_disable_o
);

  ////////////////////////////////////////////////////////////////////////////
  // strap synchroniser and reset capture

  logic [PST_SYNC_STAGES-1:0] strap_sync_r;
  logic [PST_SYNC_STAGES-1:0] strap_sync_nxt;
  logic                       strap;
  logic                       load_pend_r;
  logic                       load_pend_nxt;

  always_comb
  begin
    strap_sync_nxt = {strap_sync_r[PST_SYNC_STAGES-2:0], tuning_strap_pin_i};
    load_pend_nxt  = 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    strap_sync_r <= strap_sync_nxt;
    if (reset_i)
    begin
      load_pend_r <= 1'b1;
    end
    else
    begin
      load_pend_r <= load_pend_nxt;
    end
  end

  assign strap = strap_sync_r[PST_SYNC_STAGES-1];

  ////////////////////////////////////////////////////////////////////////////
  // system tuning register

  logic [31:0] tuning_r;
  logic [31:0] tuning_nxt;
  logic        tune_wr;

  assign tune_wr = reg_wr_i && (reg_addr_i == PST_OFS_TUNING);

  always_comb
  begin
    tuning_nxt = tuning_r;
    if (load_pend_r)
    begin
      // the strap settles through the synchroniser while reset is held
      tuning_nxt[PST_BIT_RBD] = strap; // see (RULE18)
      tuning_nxt[PST_BIT_WMD] = strap; // see (RULE18)
    end
    else if (tune_wr)
    begin
      tuning_nxt = reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      tuning_r <= PST_TUNING_RST;
    end
    else
    begin
      tuning_r <= tuning_nxt;
    end
  end

  assign ring_buffer_disable_o = tuning_r[PST_BIT_RBD] | strap; // see (RULE12) see (RULE16)
  assign watermark_disable_o   = tuning_r[PST_BIT_WMD] | strap; // see (RULE14) see (RULE17)

  ////////////////////////////////////////////////////////////////////////////
  // per-port status and control

  logic [NUM_PORTS-1:0] en_r;
  logic [NUM_PORTS-1:0] en_nxt;
  logic [NUM_PORTS-1:0] en_chg_r;
  logic [NUM_PORTS-1:0] en_chg_nxt;
  logic [NUM_PORTS-1:0] conn_chg_r;
  logic [NUM_PORTS-1:0] conn_chg_nxt;
  logic [NUM_PORTS-1:0] conn_prev_r;
  logic [NUM_PORTS-1:0] dis_req_r;
  logic [NUM_PORTS-1:0] dis_req_nxt;
  logic [NUM_PORTS-1:0] port_wr;
  logic [NUM_PORTS-1:0] port_sel;
  logic [3:0]           port_view [NUM_PORTS];

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++)
    begin : g_port
      assign port_sel[p] = (reg_addr_i == 8'(PST_OFS_PORTSC1 + 8'(p) * PST_PORT_STRIDE));
      assign port_wr[p]  = reg_wr_i && port_sel[p];

      always_comb
      begin
        en_nxt[p]       = en_r[p];
        en_chg_nxt[p]   = en_chg_r[p];
        conn_chg_nxt[p] = conn_chg_r[p];
        dis_req_nxt[p]  = dis_req_r[p];
        // clears first so a same-cycle hardware set wins
        if (port_wr[p] && reg_wdata_i[PST_BIT_EN_CHG])
        begin
          en_chg_nxt[p] = 1'b0; // see (RULE2)
        end
        if (port_wr[p] && reg_wdata_i[PST_BIT_CONN_CHG])
        begin
          conn_chg_nxt[p] = 1'b0; // see (RULE8)
        end
        // software zero asks the port engine to disable; a one is ignored
        if (port_wr[p] && !reg_wdata_i[PST_BIT_ENABLED] && en_r[p])
        begin
          dis_req_nxt[p] = 1'b1; // see (RULE3) see (RULE5)
        end
        if (reset_done_hs_i[p])
        begin
          en_nxt[p]      = 1'b1; // see (RULE4)
          dis_req_nxt[p] = 1'b0;
        end
        else if (en_r[p] && eof_error_i[p])
        begin
          en_nxt[p]      = 1'b0;
          en_chg_nxt[p]  = 1'b1; // see (RULE1)
          dis_req_nxt[p] = 1'b0;
        end
        else if (en_r[p] && (fault_i[p] || (dis_req_r[p] && port_disabled_ack_i[p])))
        begin
          // bit follows the real port state, not the write itself
          en_nxt[p]      = 1'b0; // see (RULE5)
          dis_req_nxt[p] = 1'b0;
        end
        if (connect_present_i[p] != conn_prev_r[p])
        begin
          conn_chg_nxt[p] = 1'b1; // see (RULE7)
        end
        // a vanished device leaves nothing to disable, so drop a pending request too
        if (!connect_present_i[p])
        begin
          en_nxt[p]      = 1'b0;
          dis_req_nxt[p] = 1'b0;
        end
      end

      always_ff @(posedge clk_i)
      begin
        if (reset_i)
        begin
          en_r[p]        <= PST_PORT_RST;
          en_chg_r[p]    <= PST_PORT_RST;
          conn_chg_r[p]  <= PST_PORT_RST;
          conn_prev_r[p] <= PST_PORT_RST;
          dis_req_r[p]   <= PST_PORT_RST;
        end
        else
        begin
          en_r[p]        <= en_nxt[p];
          en_chg_r[p]    <= en_chg_nxt[p];
          conn_chg_r[p]  <= conn_chg_nxt[p];
          conn_prev_r[p] <= connect_present_i[p];
          dis_req_r[p]   <= dis_req_nxt[p];
        end
      end

      // see (RULE6)
      assign data_pass_o[p] = reset_sig_i[p] || (en_r[p] && data_req_i[p]);

      // unpowered port reads all four low bits as zero
      always_comb
      begin
        port_view[p] = 4'h0;
        if (port_power_i[p])
        begin
          port_view[p][PST_BIT_PRESENT]  = connect_present_i[p]; // see (RULE9) see (RULE10)
          port_view[p][PST_BIT_CONN_CHG] = conn_chg_r[p];        // see (RULE10)
          port_view[p][PST_BIT_ENABLED]  = en_r[p];              // see (RULE10)
          port_view[p][PST_BIT_EN_CHG]   = en_chg_r[p];          // see (RULE10)
        end
      end
    end
  endgenerate

  assign port_enabled_o = en_r;
  assign disable_req_o  = dis_req_r;

  ////////////////////////////////////////////////////////////////////////////
  // read mux

  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [31:0] tune_view;

  // the register bits keep the last write; the strap masks what is read and both disable outputs
  always_comb
  begin
    tune_view              = tuning_r;
    tune_view[PST_BIT_RBD] = ring_buffer_disable_o; // see (RULE16)
    tune_view[PST_BIT_WMD] = watermark_disable_o;   // see (RULE17)
  end

  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (reg_rd_i)
    begin
      if (reg_addr_i == PST_OFS_TUNING)
      begin
        rdata_nxt = tune_view;
      end
      for (int i = 0; i < NUM_PORTS; i++)
      begin
        if (port_sel[i])
        begin
          rdata_nxt[PST_BIT_EN_CHG:PST_BIT_PRESENT] = port_view[i]; // see (RULE10)
        end
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // throughput helpers

  // ring buffering: next IN request right on completion of the previous one
  assign in_start_o = in_pkt_done_i && !ring_buffer_disable_o; // see (RULE13)

  pst_wm_if wm_bus ();

  assign wm_bus.pkt_size = out_pkt_size_i;
  assign wm_bus.fetched  = out_fetched_i;
  assign wm_bus.wm_off   = watermark_disable_o;

  pst_watermark u_wm (
    .wm (wm_bus.calc)
  );

  assign out_start_o = wm_bus.start; // see (RULE15)

endmodule

/* tb/pst_port_model.sv */
module pst_port_model
#(
  parameter int NUM_PORTS = 2
)
(
  // clock and pace
  input  wire logic                 clk_i,
  input  wire logic                 slow_i,
  // disable handshake
  input  wire logic [NUM_PORTS-1:0] disable_req_i,
  output logic      [NUM_PORTS-1:0] disabled_ack_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int wait_cnt [NUM_PORTS];
  // the port confirms only once its state has really changed, after bus delay
  always @(posedge clk_i)
  begin
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      disabled_ack_o[i] <= 1'b0;
      if (!disable_req_i[i] || disabled_ack_o[i])
        wait_cnt[i] <= 0;
      else if (wait_cnt[i] == (slow_i ? 6 : 1))
        disabled_ack_o[i] <= 1'b1;
      else
        wait_cnt[i] <= wait_cnt[i] + 1;
    end
  end
endmodule

/* tb/pst_regs_props.sv */
module pst_regs_props
  import pst_pkg::*;
#(
  parameter int NUM_PORTS = 2
)
(
  // clock, reset, register read
  input wire logic                 clk_i,
  input wire logic                 reset_i,
  input wire logic                 reg_rd_i,
  input wire logic [7:0]           reg_addr_i,
  input wire logic [31:0]          reg_rdata_o,
  // port engine
  input wire logic [NUM_PORTS-1:0] port_power_i,
  input wire logic [NUM_PORTS-1:0] reset_done_hs_i,
  input wire logic [NUM_PORTS-1:0] eof_error_i,
  input wire logic [NUM_PORTS-1:0] fault_i,
  input wire logic [NUM_PORTS-1:0] data_req_i,
  input wire logic [NUM_PORTS-1:0] reset_sig_i,
  input wire logic [NUM_PORTS-1:0] port_enabled_o,
  input wire logic [NUM_PORTS-1:0] data_pass_o,
  // tuning
  input wire logic                 tuning_strap_pin_i,
  input wire logic                 in_pkt_done_i,
  input wire logic                 in_start_o,
  input wire logic [10:0]          out_pkt_size_i,
  input wire logic [10:0]          out_fetched_i,
  input wire logic                 out_start_o,
  input wire logic                 ring_buffer_disable_o,
  input wire logic                 watermark_disable_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  //////////////////////////////////////////////////////////////////////////
  a_en_source: assert property ($rose(port_enabled_o[0]) |-> $past(reset_done_hs_i[0]))
    else $error("port enabled without high-speed reset");
  a_fault_clears: assert property ((fault_i[0] || eof_error_i[0]) && !reset_done_hs_i[0]
    |=> !port_enabled_o[0]) else $error("port still enabled after fault");
  a_pass_gate: assert property (data_pass_o == (reset_sig_i | (port_enabled_o & data_req_i)))
    else $error("downstream pass gating wrong");
  a_power_mask: assert property (reg_rd_i && reg_addr_i == PST_OFS_PORTSC1 && !port_power_i[0]
    |=> reg_rdata_o[3:0] == 4'h0) else $error("unpowered port bits not masked");
  a_ring_start: assert property (in_start_o == (in_pkt_done_i && !ring_buffer_disable_o))
    else $error("ring start wrong");
  a_wm_off: assert property (watermark_disable_o && out_fetched_i < out_pkt_size_i
    |-> !out_start_o) else $error("early start with watermark off");
  a_wm_level: assert property (!watermark_disable_o && out_pkt_size_i == 11'h400
    && out_fetched_i >= 11'h2ff |-> out_start_o) else $error("no start at watermark");
  a_strap_force: assert property (tuning_strap_pin_i [*3]
    |-> ring_buffer_disable_o && watermark_disable_o) else $error("strap not forcing off");
  c_eof: cover property (eof_error_i[0]);
  c_wm: cover property (out_start_o && out_fetched_i < out_pkt_size_i);
  c_strap: cover property (tuning_strap_pin_i && ring_buffer_disable_o);
endmodule

bind pst_regs pst_regs_props #(
  .NUM_PORTS(NUM_PORTS)
) u_props (
  .clk_i                 (clk_i),
  .reset_i               (reset_i),
  .reg_rd_i              (reg_rd_i),
  .reg_addr_i            (reg_addr_i),
  .reg_rdata_o           (reg_rdata_o),
  .port_power_i          (port_power_i),
  .reset_done_hs_i       (reset_done_hs_i),
  .eof_error_i           (eof_error_i),
  .fault_i               (fault_i),
  .data_req_i            (data_req_i),
  .reset_sig_i           (reset_sig_i),
  .port_enabled_o        (port_enabled_o),
  .data_pass_o           (data_pass_o),
  .tuning_strap_pin_i    (tuning_strap_pin_i),
  .in_pkt_done_i         (in_pkt_done_i),
  .in_start_o            (in_start_o),
  .out_pkt_size_i        (out_pkt_size_i),
  .out_fetched_i         (out_fetched_i),
  .out_start_o           (out_start_o),
  .ring_buffer_disable_o (ring_buffer_disable_o),
  .watermark_disable_o   (watermark_disable_o)
);

/* tb/pst_regs_test.sv */
module pst_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  import pst_pkg::*;
  logic        clk_i = 1'b0, reset_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
  logic [1:0]  port_power_i = 2'h3, connect_present_i = 2'h0, reset_done_hs_i = 2'h0;
  logic [1:0]  eof_error_i = 2'h0, fault_i = 2'h0, data_req_i = 2'h3, reset_sig_i = 2'h0;
  logic [1:0]  port_disabled_ack_i, port_enabled_o, disable_req_o, data_pass_o;
  logic        tuning_strap_pin_i = 1'b0, in_pkt_done_i = 1'b0, in_start_o, out_start_o;
  logic        ring_buffer_disable_o, watermark_disable_o;
  logic [10:0] out_pkt_size_i = 11'h0, out_fetched_i = 11'h0;
  int          errors = 0;
  int          compares = 0;
  always #25 clk_i = ~clk_i;
  pst_regs #(
    .NUM_PORTS(2)
  ) uut (
    .clk_i                 (clk_i),
    .reset_i               (reset_i),
    .reg_wr_i              (reg_wr_i),
    .reg_rd_i              (reg_rd_i),
    .reg_addr_i            (reg_addr_i),
    .reg_wdata_i           (reg_wdata_i),
    .reg_rdata_o           (reg_rdata_o),
    .port_power_i          (port_power_i),
    .connect_present_i     (connect_present_i),
    .reset_done_hs_i       (reset_done_hs_i),
    .eof_error_i           (eof_error_i),
    .fault_i               (fault_i),
    .port_disabled_ack_i   (port_disabled_ack_i),
    .data_req_i            (data_req_i),
    .reset_sig_i           (reset_sig_i),
    .port_enabled_o        (port_enabled_o),
    .disable_req_o         (disable_req_o),
    .data_pass_o           (data_pass_o),
    .tuning_strap_pin_i    (tuning_strap_pin_i),
    .in_pkt_done_i         (in_pkt_done_i),
    .in_start_o            (in_start_o),
    .out_pkt_size_i        (out_pkt_size_i),
    .out_fetched_i         (out_fetched_i),
    .out_start_o           (out_start_o),
    .ring_buffer_disable_o (ring_buffer_disable_o),
    .watermark_disable_o   (watermark_disable_o)
  );
  pst_port_model #(.NUM_PORTS(2)) partner (.clk_i(clk_i), .slow_i(1'b1),
    .disable_req_i(disable_req_o), .disabled_ack_o(port_disabled_ack_i));
  //////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    tick();
    reg_wr_i = 1'b0;
    // one idle edge so a following call never re-raises the strobe in the same step
    tick();
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    tick();
    reg_rd_i = 1'b0;
    chk(nm, reg_rdata_o, exp);
    tick();
  endtask
  // k: 0 high-speed reset done, 1 end-of-frame error, 2 fault, on port one
  task automatic ev(input int k);
    {fault_i[0], eof_error_i[0], reset_done_hs_i[0]} = 3'h1 << k;
    tick();
    {fault_i[0], eof_error_i[0], reset_done_hs_i[0]} = 3'h0;
    tick();
  endtask
  task automatic wm(input logic [10:0] size, input logic [10:0] got, input logic exp);
    out_pkt_size_i = size;
    out_fetched_i = got;
    tick();
    chk("out start", 32'(out_start_o), 32'(exp));
  endtask
  task automatic close_out();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    tick(16);
    reset_i = 1'b0;
    tick(2);
    rd("tuning reset", PST_OFS_TUNING, 32'h0);
    rd("unmapped", 8'h70, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      connect_present_i = 2'(i % 2 == 0);
      tick();
    end
    rd("attach", PST_OFS_PORTSC1, 32'h3);
    wr(PST_OFS_PORTSC1, 32'h0);
    rd("change kept", PST_OFS_PORTSC1, 32'h3);
    wr(PST_OFS_PORTSC1, 32'h6);
    rd("change clear", PST_OFS_PORTSC1, 32'h1);
    ev(0);
    rd("enabled", PST_OFS_PORTSC1, 32'h5);
    chk("pass on", 32'(data_pass_o), 32'h1);
    ev(1);
    rd("eof", PST_OFS_PORTSC1, 32'h9);
    chk("pass off", 32'(data_pass_o), 32'h0);
    reset_sig_i = 2'h1;
    tick();
    chk("pass reset", 32'(data_pass_o), 32'h1);
    reset_sig_i = 2'h0;
    wr(PST_OFS_PORTSC1, 32'h8);
    rd("eof clear", PST_OFS_PORTSC1, 32'h1);
    ev(0);
    wr(PST_OFS_PORTSC1, 32'h0);
    chk("disable req", 32'(disable_req_o), 32'h1);
    rd("not yet off", PST_OFS_PORTSC1, 32'h5);
    for (int i = 0; i < 20 && port_enabled_o[0] !== 1'b0; i++)
      tick();
    chk("enabled pin", 32'(port_enabled_o), 32'h0);
    chk("disable done", 32'(disable_req_o), 32'h0);
    rd("software off", PST_OFS_PORTSC1, 32'h1);
    ev(0);
    ev(2);
    rd("fault", PST_OFS_PORTSC1, 32'h1);
    port_power_i = 2'h2;
    connect_present_i = 2'h3;
    tick();
    rd("power off", PST_OFS_PORTSC1, 32'h0);
    rd("port two", PST_OFS_PORTSC2, 32'h3);
    $display("test ports done");
    in_pkt_done_i = 1'b1;
    tick();
    chk("ring on", 32'(in_start_o), 32'h1);
    wr(PST_OFS_TUNING, 32'h3);
    rd("tuning", PST_OFS_TUNING, 32'h3);
    chk("ring off", 32'(in_start_o), 32'h0);
    in_pkt_done_i = 1'b0;
    wr(PST_OFS_TUNING, 32'h2);
    for (int i = 0; i < PST_WM_COUNT; i++)
    begin
      wm(PST_WM_LEVEL[i] + 11'h1, PST_WM_LEVEL[i], 1'b1);
      wm(PST_WM_LEVEL[i] + 11'h1, PST_WM_LEVEL[i] - 11'h1, 1'b0);
    end
    wm(11'h400, 11'h2ff, 1'b1);
    wm(11'h0bf, 11'h0be, 1'b0);
    wm(11'h0bf, 11'h0bf, 1'b1);
    wr(PST_OFS_TUNING, 32'h1);
    wm(11'h400, 11'h2ff, 1'b0);
    $display("test tuning done");
    tuning_strap_pin_i = 1'b1;
    in_pkt_done_i = 1'b1;
    wr(PST_OFS_TUNING, 32'h0);
    tick(2);
    rd("strap", PST_OFS_TUNING, 32'h3);
    chk("strap outs", 32'({ring_buffer_disable_o, watermark_disable_o}), 32'h3);
    chk("strap ring", 32'(in_start_o), 32'h0);
    in_pkt_done_i = 1'b0;
    reset_i = 1'b1;
    tick(4);
    reset_i = 1'b0;
    tuning_strap_pin_i = 1'b0;
    tick(4);
    rd("strap load", PST_OFS_TUNING, 32'h3);
    $display("test strap done");
    close_out();
  end
  // the tests need about 115 cycles; give over eight times that before calling it a hang
  initial
  begin
    #(1000 * 50);
    errors++;
    $display("[FAIL] watchdog expected finish seen hang");
    close_out();
  end
endmodule
